// ### src/anes_top.sv
// auto-negotiation expansion status register with a classic wishbone slave
// Functional notes
// - reserved bits 15:5 always read zero
// - reserved bits writable only under override
// - bit 4 latches parallel detection fault
// - bit 3 shows partner next page
// - bit 2 always one, local next page
// - bit 1 latches new page received
// - a read of the expansion register clears page received
// - bit 0 set by valid pulse bursts
`timescale 1ns/1ps
`default_nettype none
module anes_top
    import anes_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // negotiation status from the core
    input wire logic par_fault_i,
    input wire logic lp_np_i,
    input wire logic page_rcvd_i,
    input wire logic flp_valid_i,
    // override state and reserved bit contents
    output logic override_o,
    output logic [ANES_CW_W-1:0] override_writable_bit_o
);
    anes_state_t s_reg;
    anes_state_t s_next;
    logic req;
    logic hit_exp;
    logic hit_ovr;
    logic rd_clr;
    logic pf_flag;
    logic pr_flag;
    logic [15:0] exp_view;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // answer one cycle after the request; ack low again next cycle
    assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign hit_exp = (wb_adr_i[7:2] == ANES_EXP_ADDR[7:2]);
    assign hit_ovr = (wb_adr_i[7:2] == ANES_OVR_ADDR[7:2]);
    // the clear lands on the same edge the read data is captured
    assign rd_clr = req & ~wb_we_i & hit_exp;

    // ------------------------------------------------------------
    // latching flags
    // ------------------------------------------------------------
    anes_latch_high_flag u_pf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(par_fault_i),
        .rd_clr_i(rd_clr),
        .flag_o(pf_flag)
    );

    anes_latch_high_flag u_pr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(page_rcvd_i),
        .rd_clr_i(rd_clr),
        .flag_o(pr_flag)
    );

    // ------------------------------------------------------------
    // read view
    // ------------------------------------------------------------
    always_comb begin
        exp_view = 16'h0000;
        // stored reserved contents are never shown to the station
        exp_view[ANES_CW_HI:ANES_CW_LO] = '0;
        exp_view[ANES_PF_BIT] = pf_flag;
        exp_view[ANES_LPNP_BIT] = s_reg.lp_np;
        exp_view[ANES_NP_BIT] = ANES_NP_ABLE;
        exp_view[ANES_PR_BIT] = pr_flag;
        exp_view[ANES_LPAN_BIT] = s_reg.lp_an;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rst_seen = 1'b0;
        s_next.ack = req;
        s_next.lp_np = lp_np_i;
        s_next.lp_an = flp_valid_i;
        if (req) begin
            s_next.dat = ANES_DAT_RST;
            if (!wb_we_i) begin
                if (hit_exp) begin
                    s_next.dat[15:0] = exp_view;
                end else if (hit_ovr) begin
                    s_next.dat[ANES_OVR_BIT] = s_reg.override;
                end
            end else if (hit_exp) begin
                // bits 4:0 take no write at all
                if (s_reg.override) begin
                    if (wb_sel_i[0]) begin
                        s_next.cw[2:0] = wb_dat_i[7:5];
                    end
                    if (wb_sel_i[1]) begin
                        s_next.cw[ANES_CW_W-1:3] = wb_dat_i[15:8];
                    end
                end
            end else if (hit_ovr && wb_sel_i[1]) begin
                s_next.override = wb_dat_i[ANES_OVR_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.ack <= 1'b0;
            s_reg.dat <= ANES_DAT_RST;
            s_reg.override <= ANES_OVR_RST;
            s_reg.cw <= ANES_CW_RST;
            s_reg.lp_np <= ANES_FLAG_RST;
            s_reg.lp_an <= ANES_FLAG_RST;
            s_reg.rst_seen <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
    assign override_o = s_reg.override;
    assign override_writable_bit_o = s_reg.cw;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_exp_read;
        req && !wb_we_i && hit_exp;
    endsequence

    sequence s_exp_write;
        req && wb_we_i && hit_exp;
    endsequence

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (rst_i)
        s_exp_read |=> wb_ack_o && (wb_dat_o[15:5] == 11'h000) && (wb_dat_o[31:16] == 16'h0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits read non-zero");

    property p_cw_locked;
        @(posedge clk_i) disable iff (rst_i)
        (s_exp_write and !override_o) |=> $stable(override_writable_bit_o);
    endproperty
    a_cw_locked: assert property (p_cw_locked)
        else $error("reserved bits changed without override");

    property p_cw_open;
        @(posedge clk_i) disable iff (rst_i)
        (s_exp_write and (override_o && (wb_sel_i == 4'h3)))
        |=> override_writable_bit_o == $past(wb_dat_i[15:5]);
    endproperty
    a_cw_open: assert property (p_cw_open)
        else $error("reserved bits not written under override");

    property p_pf_set;
        @(posedge clk_i) disable iff (rst_i)
        par_fault_i |=> pf_flag;
    endproperty
    a_pf_set: assert property (p_pf_set)
        else $error("parallel fault not latched");

    property p_lpnp;
        @(posedge clk_i) disable iff (rst_i)
        s_exp_read ##1 1'b1 |-> wb_dat_o[ANES_LPNP_BIT] == $past(s_reg.lp_np);
    endproperty
    a_lpnp: assert property (p_lpnp)
        else $error("partner next page bit misreported");

    property p_np_able;
        @(posedge clk_i) disable iff (rst_i)
        s_exp_read |=> wb_dat_o[ANES_NP_BIT];
    endproperty
    a_np_able: assert property (p_np_able)
        else $error("local next page bit not one");

    property p_pr_set;
        @(posedge clk_i) disable iff (rst_i)
        page_rcvd_i |=> pr_flag;
    endproperty
    a_pr_set: assert property (p_pr_set)
        else $error("page received not latched");

    property p_pr_clear;
        @(posedge clk_i) disable iff (rst_i)
        (s_exp_read and !page_rcvd_i) |=> !pr_flag;
    endproperty
    a_pr_clear: assert property (p_pr_clear)
        else $error("page received survived a read");

    property p_lpan;
        @(posedge clk_i) disable iff (rst_i)
        !flp_valid_i ##1 !flp_valid_i |=> !s_reg.lp_an;
    endproperty
    a_lpan: assert property (p_lpan)
        else $error("partner able set without pulse bursts");

    property p_reset_flags;
        @(posedge clk_i) disable iff (rst_i)
        s_reg.rst_seen |-> !pf_flag && !pr_flag && !s_reg.lp_np && !s_reg.lp_an;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("status flags not zero after reset");
endmodule
`default_nettype wire

// ### src/anes_pkg.sv
// constants and state types for the auto-negotiation expansion status block
package anes_pkg;
    // ------------------------------------------------------------
    // register map (index times four is the byte address)
    // ------------------------------------------------------------
    localparam logic [5:0] ANES_EXP_IDX = 6'h06;
    localparam logic [5:0] ANES_OVR_IDX = 6'h10;
    localparam logic [7:0] ANES_EXP_ADDR = {ANES_EXP_IDX, 2'b00};
    localparam logic [7:0] ANES_OVR_ADDR = {ANES_OVR_IDX, 2'b00};
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ANES_CW_HI = 15;
    localparam int ANES_CW_LO = 5;
    localparam int ANES_CW_W = ANES_CW_HI - ANES_CW_LO + 1;
    localparam int ANES_PF_BIT = 4;
    localparam int ANES_LPNP_BIT = 3;
    localparam int ANES_NP_BIT = 2;
    localparam int ANES_PR_BIT = 1;
    localparam int ANES_LPAN_BIT = 0;
    localparam int ANES_OVR_BIT = 15;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ANES_CW_W-1:0] ANES_CW_RST = 11'h000;
    localparam logic ANES_NP_ABLE = 1'b1;
    localparam logic ANES_FLAG_RST = 1'b0;
    localparam logic ANES_OVR_RST = 1'b0;
    localparam logic [31:0] ANES_DAT_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef struct packed {
        logic flag;
    } anes_latch_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic override;
        logic [ANES_CW_W-1:0] cw;
        logic lp_np;
        logic lp_an;
        logic rst_seen;
    } anes_state_t;
endpackage

// ### src/anes_latch_high_flag.sv
// latching-high status flag with clear on read
`timescale 1ns/1ps
`default_nettype none
module anes_latch_high_flag
    import anes_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // condition and read clear
    input wire logic cond_i,
    input wire logic rd_clr_i,
    // flag
    output logic flag_o
);
    anes_latch_t s_reg;
    anes_latch_t s_next;

    // ------------------------------------------------------------
    // flag logic
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // a set in the clearing cycle wins, so an event is never lost
        s_next.flag = cond_i | (s_reg.flag & ~rd_clr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.flag <= ANES_FLAG_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign flag_o = s_reg.flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_held;
        flag_o && !rd_clr_i;
    endsequence

    property p_hold_until_read;
        @(posedge clk_i) disable iff (rst_i)
        s_held |=> flag_o;
    endproperty
    a_hold_until_read: assert property (p_hold_until_read)
        else $error("latched flag dropped without a read");

    property p_read_follows_cond;
        @(posedge clk_i) disable iff (rst_i)
        rd_clr_i |=> (flag_o == $past(cond_i));
    endproperty
    a_read_follows_cond: assert property (p_read_follows_cond)
        else $error("flag after read does not show the condition");
endmodule
`default_nettype wire

// ### sim/anes_sta.sv
// station model that reads and writes management registers over classic wishbone
`timescale 1ns/1ps
`default_nettype none
module anes_sta (
    // clock
    input wire logic clk_i,
    // wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic ack_i,
    input wire logic [31:0] dat_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end
    // one classic cycle; request held until the edge that samples ack
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= 4'h3;
        dat_o <= wd;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released lines never show the last value
        we_o <= ~we;
        adr_o <= ~adr;
        sel_o <= 4'hc;
        dat_o <= ~wd;
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the expansion status register against a bench model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import anes_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, ovr;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, dat, rd, r;
    logic [10:0] cw, m_cw;
    logic par_fault = 1'b0, lp_np = 1'b0, page_rcvd = 1'b0, flp_valid = 1'b0;
    logic m_pf, m_pr;
    int n_mismatch = 0;
    int compares = 0;
    always #12.5 clk_i = ~clk_i;
    anes_sta sta (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wd), .ack_i(ack), .dat_i(dat));
    anes_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack),
        .wb_dat_o(dat), .par_fault_i(par_fault), .lp_np_i(lp_np), .page_rcvd_i(page_rcvd),
        .flp_valid_i(flp_valid), .override_o(ovr), .override_writable_bit_o(cw));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim();
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the read clears latched flags to whatever condition stands then
    task automatic rd_exp();
        sta.xfer(1'b0, ANES_EXP_ADDR, 32'h0000_0000, rd);
        chk("expansion", rd, {27'h0, m_pf, lp_np, 1'b1, m_pr, flp_valid});
        m_pf = par_fault;
        m_pr = page_rcvd;
    endtask
    task automatic hit(input logic pf, input logic pr);
        @(posedge clk_i);
        par_fault <= pf;
        page_rcvd <= pr;
        @(posedge clk_i);
        par_fault <= 1'b0;
        page_rcvd <= 1'b0;
        m_pf = m_pf | pf;
        m_pr = m_pr | pr;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (2000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
    initial begin
        m_pf = 1'b0;
        m_pr = 1'b0;
        r = 32'h31f7;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_exp();
        sta.xfer(1'b0, ANES_OVR_ADDR, 32'h0000_0000, rd);
        chk("override", rd, 32'h0000_0000);
        sta.xfer(1'b1, ANES_EXP_ADDR, 32'hffff_ffff, rd);
        chk("cw locked", {21'h0, cw}, 32'h0000_0000);
        rd_exp();
        hit(1'b0, 1'b1);
        rd_exp();
        rd_exp();
        hit(1'b1, 1'b0);
        rd_exp();
        rd_exp();
        // fault held across reads, then dropped
        @(posedge clk_i);
        par_fault <= 1'b1;
        m_pf = 1'b1;
        repeat (3) @(posedge clk_i);
        rd_exp();
        rd_exp();
        @(posedge clk_i);
        par_fault <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd_exp();
        rd_exp();
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            @(posedge clk_i);
            lp_np <= r[0];
            flp_valid <= r[1];
            hit(r[2], r[3]);
            rd_exp();
        end
        sta.xfer(1'b1, ANES_OVR_ADDR, 32'h0000_8000, rd);
        chk("override set", {31'h0, ovr}, 32'h0000_0001);
        sta.xfer(1'b0, ANES_OVR_ADDR, 32'h0000_0000, rd);
        chk("override read", rd, 32'h0000_8000);
        r = lfsr(r);
        m_cw = r[15:5];
        sta.xfer(1'b1, ANES_EXP_ADDR, r, rd);
        chk("cw open", {21'h0, cw}, {21'h0, m_cw});
        rd_exp();
        sta.xfer(1'b1, ANES_EXP_ADDR, 32'h0000_0000, rd);
        chk("cw default", {21'h0, cw}, 32'h0000_0000);
        sta.xfer(1'b1, ANES_OVR_ADDR, 32'h0000_0000, rd);
        sta.xfer(1'b1, ANES_EXP_ADDR, 32'hffff_ffe0, rd);
        chk("cw relocked", {21'h0, cw}, 32'h0000_0000);
        sta.xfer(1'b0, 8'h80, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
        // second reset with flags latched
        hit(1'b1, 1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m_pf = 1'b0;
        m_pr = 1'b0;
        rd_exp();
        end_sim();
    end
endmodule
`default_nettype wire
